//--- src/gpc_port.v
// APB slave holding the per-pin configuration of a 16-pin port and its pad control.
`include "gpc_map.vh"
module gpc_port #(
	parameter PINS = 16,
	parameter [31:0] MODE_RESET = `GPC_RST_MODE,
	parameter [31:0] SLEW_RESET = `GPC_RST_SLEW,
	parameter [31:0] PULL_RESET = `GPC_RST_PULL,
	parameter [3:0] CRYSTAL_INPUT_PIN_PIN = 4'h0,
	parameter [3:0] OSC_OUT_PIN = 4'h1
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	input wire [PINS-1:0] pad_in,
	output wire [PINS-1:0] pad_out,
	output wire [PINS-1:0] pad_oe,
	output wire [PINS-1:0] pad_pull_up,
	output wire [PINS-1:0] pad_pull_down,
	output wire [PINS-1:0] pad_in_enable,
	output wire [2*PINS-1:0] pad_slew,
	input wire [PINS-1:0] peripheral_function_out,
	output wire [PINS-1:0] peripheral_function_in,
	output wire [2*PINS-1:0] pin_function_field,
	output wire [PINS-1:0] drive_type_bit
);
	// Configuration registers; the _d values are the next state of the _q flip-flops.
	reg [31:0] mode_q;
	reg [31:0] mode_d;
	reg [15:0] type_q;
	reg [15:0] type_d;
	reg [31:0] slew_q;
	reg [31:0] slew_d;
	reg [31:0] pull_q;
	reg [31:0] pull_d;
	reg [15:0] odata_q;
	reg [15:0] odata_d;
	reg [1:0] osc_q;
	reg [1:0] osc_d;
	reg [15:0] sample_q;
	reg [31:0] rdata_d;
	wire [15:0] sample_d;

	// Byte-lane merges of the written word into the mode, type, slew, pull and output data registers.
	wire [31:0] mode_merge;
	wire [15:0] type_merge;
	wire [31:0] slew_merge;
	wire [31:0] pull_merge;
	wire [15:0] odata_merge;

	// Bus decode.
	wire setup_phase;
	wire access_phase;
	wire wr_en;
	wire rd_setup;
	wire sel_mode;
	wire sel_type;
	wire sel_slew;
	wire sel_pull;
	wire sel_sample;
	wire sel_odata;
	wire sel_osc;
	wire addr_hit;
	wire [31:0] bmask;
	wire [15:0] bmask_lo;

	// Read values, with reserved bits already zero.
	wire [31:0] mode_rd;
	wire [31:0] type_rd;
	wire [31:0] slew_rd;
	wire [31:0] pull_rd;
	wire [31:0] sample_rd;
	wire [31:0] odata_rd;
	wire [31:0] osc_rd;

	// Pin-side decode.
	wire osc_on;
	wire osc_ext;
	wire [15:0] crystal_input_pin_bit;
	wire [15:0] osc_out_bit;
	wire [15:0] reserved_pins;
	wire [PINS-1:0] rx_on;

	// Zero wait states: every access completes in its first access cycle.
	assign pready = 1'b1;
	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable;
	assign wr_en = access_phase & pwrite;
	assign rd_setup = setup_phase & ~pwrite;

	assign sel_mode = (paddr == `GPC_OFS_MODE);
	assign sel_type = (paddr == `GPC_OFS_TYPE);
	assign sel_slew = (paddr == `GPC_OFS_SLEW);
	assign sel_pull = (paddr == `GPC_OFS_PULL);
	assign sel_sample = (paddr == `GPC_OFS_SAMPLE);
	assign sel_odata = (paddr == `GPC_OFS_OUTDATA);
	assign sel_osc = (paddr == `GPC_OFS_OSCCTL);
	assign addr_hit = sel_mode | sel_type | sel_slew | sel_pull |
		sel_sample | sel_odata | sel_osc;

	// Holes in the map answer with an error and their writes are dropped.
	assign pslverr = access_phase & ~addr_hit; // [RQ18]

	// Byte lanes are honoured so narrower CPU stores touch only their bytes.
	assign bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}}; // [RQ10]
	assign bmask_lo = bmask[15:0];

	gpc_lane_merge #(
		.WIDTH(32)
	) u_mode_merge (
		.old_word(mode_q),
		.new_word(pwdata),
		.lane_mask(bmask),
		.merged(mode_merge)
	);

	gpc_lane_merge #(
		.WIDTH(16)
	) u_type_merge (
		.old_word(type_q),
		.new_word(pwdata[15:0]),
		.lane_mask(bmask_lo),
		.merged(type_merge)
	);

	gpc_lane_merge #(
		.WIDTH(32)
	) u_slew_merge (
		.old_word(slew_q),
		.new_word(pwdata),
		.lane_mask(bmask),
		.merged(slew_merge)
	);

	gpc_lane_merge #(
		.WIDTH(32)
	) u_pull_merge (
		.old_word(pull_q),
		.new_word(pwdata),
		.lane_mask(bmask),
		.merged(pull_merge)
	);

	gpc_lane_merge #(
		.WIDTH(16)
	) u_odata_merge (
		.old_word(odata_q),
		.new_word(pwdata[15:0]),
		.lane_mask(bmask_lo),
		.merged(odata_merge)
	);

	// Port-specific reset values come in through the parameters.
	always @* begin
		mode_d = mode_q;
		if (wr_en & sel_mode) begin
			mode_d = mode_merge; // [RQ10] [RQ11]
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= MODE_RESET; // [RQ12]
		end else begin
			mode_q <= mode_d;
		end
	end

	// Only the low half exists; the upper half of a write is dropped.
	always @* begin
		type_d = type_q;
		if (wr_en & sel_type) begin
			type_d = type_merge; // [RQ13] [RQ18]
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			type_q <= `GPC_RST_TYPE; // [RQ13]
		end else begin
			type_q <= type_d;
		end
	end

	always @* begin
		slew_d = slew_q;
		if (wr_en & sel_slew) begin
			slew_d = slew_merge; // [RQ14]
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slew_q <= SLEW_RESET; // [RQ15]
		end else begin
			slew_q <= slew_d;
		end
	end

	always @* begin
		pull_d = pull_q;
		if (wr_en & sel_pull) begin
			pull_d = pull_merge; // [RQ16]
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pull_q <= PULL_RESET; // [RQ17]
		end else begin
			pull_q <= pull_d;
		end
	end

	always @* begin
		odata_d = odata_q;
		if (wr_en & sel_odata) begin
			odata_d = odata_merge; // [RQ10]
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			odata_q <= `GPC_RST_OUTDATA;
		end else begin
			odata_q <= odata_d;
		end
	end

	// The oscillator control sits in the lowest byte lane only.
	always @* begin
		osc_d = osc_q;
		if (wr_en & sel_osc & pstrb[0]) begin
			osc_d = pwdata[1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_q <= `GPC_RST_OSC; // [RQ8]
		end else begin
			osc_q <= osc_d;
		end
	end

	// The oscillator takes its pins only when enabled; external clock keeps just the input.
	assign osc_on = osc_q[`GPC_OSC_EN_BIT];
	assign osc_ext = osc_q[`GPC_OSC_EXT_BIT];
	assign crystal_input_pin_bit = `GPC_PIN_ONE << CRYSTAL_INPUT_PIN_PIN;
	assign osc_out_bit = `GPC_PIN_ONE << OSC_OUT_PIN;
	assign reserved_pins = osc_on ? (osc_ext ? crystal_input_pin_bit : (crystal_input_pin_bit | osc_out_bit)) :
		`GPC_PIN_NONE; // [RQ8] [RQ9]

	genvar g;
	generate
		for (g = 0; g < PINS; g = g + 1) begin : pin
			gpc_pin_ctl u_gpc_pin_ctl (
				.mode_field(mode_q[2*g+1:2*g]),
				.pull_field(pull_q[2*g+1:2*g]),
				.open_drain(type_q[g]),
				.out_data(odata_q[g]),
				.alt_data(peripheral_function_out[g]),
				.osc_reserved(reserved_pins[g]),
				.pad_out(pad_out[g]),
				.pad_oe(pad_oe[g]),
				.pull_up(pad_pull_up[g]),
				.pull_down(pad_pull_down[g]),
				.rx_on(rx_on[g])
			);
			assign pad_slew[2*g+1:2*g] = slew_q[2*g+1:2*g]; // [RQ14]
			assign pin_function_field[2*g+1:2*g] = mode_q[2*g+1:2*g]; // [RQ11]
		end
	endgenerate

	assign pad_in_enable = rx_on; // [RQ2]
	assign drive_type_bit = type_q;
	assign peripheral_function_in = sample_q; // [RQ2]

	// Sampled each clock; a disabled receiver reads as zero.
	assign sample_d = pad_in & rx_on; // [RQ4] [RQ6]

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_q <= `GPC_RST_SAMPLE;
		end else begin
			sample_q <= sample_d;
		end
	end

	assign mode_rd = mode_q;
	assign type_rd = {`GPC_ZERO_HALF, type_q}; // [RQ18]
	assign slew_rd = slew_q;
	assign pull_rd = pull_q;
	assign sample_rd = {`GPC_ZERO_HALF, sample_q}; // [RQ4]
	assign odata_rd = {`GPC_ZERO_HALF, odata_q}; // [RQ18]
	assign osc_rd = {`GPC_ZERO_OSC, osc_q}; // [RQ18]

	always @* begin
		rdata_d = `GPC_ZERO_WORD;
		case (paddr)
		`GPC_OFS_MODE: rdata_d = mode_rd;
		`GPC_OFS_TYPE: rdata_d = type_rd;
		`GPC_OFS_SLEW: rdata_d = slew_rd;
		`GPC_OFS_PULL: rdata_d = pull_rd;
		`GPC_OFS_SAMPLE: rdata_d = sample_rd;
		`GPC_OFS_OUTDATA: rdata_d = odata_rd;
		`GPC_OFS_OSCCTL: rdata_d = osc_rd;
		default: rdata_d = `GPC_ZERO_WORD; // [RQ18]
		endcase
	end

	// Read data is captured in the setup cycle, so the access cycle sees a flip-flop.
	// A pin sample read this way is one clock older than the access cycle.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `GPC_ZERO_WORD;
		end else if (rd_setup) begin
			prdata <= rdata_d;
		end
	end
endmodule

// Byte-lane merge: lanes with a set mask bit take the new word.
module gpc_lane_merge #(
	parameter WIDTH = 32
) (
	input wire [WIDTH-1:0] old_word,
	input wire [WIDTH-1:0] new_word,
	input wire [WIDTH-1:0] lane_mask,
	output wire [WIDTH-1:0] merged
);
	assign merged = (old_word & ~lane_mask) | (new_word & lane_mask); // [RQ10]
endmodule

// Per-pin decode of mode, type and pull into pad controls.
module gpc_pin_ctl (
	input wire [1:0] mode_field,
	input wire [1:0] pull_field,
	input wire open_drain,
	input wire out_data,
	input wire alt_data,
	input wire osc_reserved,
	output wire pad_out,
	output wire pad_oe,
	output wire pull_up,
	output wire pull_down,
	output wire rx_on
);
	wire is_output;
	wire is_alt;
	wire is_analog;
	wire drive_en;
	wire drive_val;

	assign is_output = (mode_field == `GPC_MODE_OUTPUT); // [RQ11]
	assign is_alt = (mode_field == `GPC_MODE_ALT); // [RQ11]
	assign is_analog = (mode_field == `GPC_MODE_ANALOG); // [RQ11]

	// Analog mode and oscillator pins never drive, whatever type and data say.
	assign drive_en = (is_output | is_alt) & ~osc_reserved; // [RQ5] [RQ8]
	assign drive_val = is_alt ? alt_data : out_data; // [RQ1]

	// Open drain only ever pulls low; a one leaves the pin to its pull or the outside.
	assign pad_out = drive_val & ~open_drain;
	assign pad_oe = drive_en & (~open_drain | ~drive_val); // [RQ1] [RQ13]
	assign rx_on = ~is_analog & ~osc_reserved; // [RQ2] [RQ6]

	// Analog pins have their pulls cut here too, in case software leaves them set.
	assign pull_up = rx_on & (pull_field == `GPC_PULL_UP); // [RQ3] [RQ7] [RQ16]
	assign pull_down = rx_on & (pull_field == `GPC_PULL_DOWN); // [RQ3] [RQ7] [RQ16]
endmodule

//--- pkg/gpc_map.vh
// Register map, field codes and reset values of the GPIO pin configuration block.
// Operation
// RQ1 - Alternate mode drives pad from peripheral output.
// RQ2 - Alternate mode keeps input receiver active.
// RQ3 - Alternate mode applies pulls per pull field.
// RQ4 - Alternate mode samples pin every clock.
// RQ5 - Analog mode turns output driver off.
// RQ6 - Analog mode forces sampled input low.
// RQ7 - Analog mode leaves pulls inactive; software sets none.
// RQ8 - Oscillator off: pins ordinary; on: software analog.
// RQ9 - External clock mode reserves only clock pin.
// RQ10 - Byte, half-word and word writes honour strobes.
// RQ11 - Mode field: input, output, alternate, analog.
// RQ12 - Mode register resets to port-specific value.
// RQ13 - Drive type bit per pin, upper half reserved.
// RQ14 - Slew field gives four speed grades.
// RQ15 - Slew register reset value per port.
// RQ16 - Pull field: none, up, down, reserved.
// RQ17 - Pull register reset value per port.
// RQ18 - Reserved bits read zero, writes ignored.
`ifndef GPC_MAP_VH
`define GPC_MAP_VH
`define GPC_OFS_MODE 12'h000
`define GPC_OFS_TYPE 12'h004
`define GPC_OFS_SLEW 12'h008
`define GPC_OFS_PULL 12'h00c
`define GPC_OFS_SAMPLE 12'h010
`define GPC_OFS_OUTDATA 12'h014
`define GPC_OFS_OSCCTL 12'h020
`define GPC_MODE_INPUT 2'h0
`define GPC_MODE_OUTPUT 2'h1
`define GPC_MODE_ALT 2'h2
`define GPC_MODE_ANALOG 2'h3
`define GPC_PULL_NONE 2'h0
`define GPC_PULL_UP 2'h1
`define GPC_PULL_DOWN 2'h2
`define GPC_RST_MODE 32'hebffffff
`define GPC_RST_TYPE 16'h0000
`define GPC_RST_SLEW 32'h0c000000
`define GPC_RST_PULL 32'h24000000
`define GPC_RST_OUTDATA 16'h0000
`define GPC_OSC_EN_BIT 0
`define GPC_OSC_EXT_BIT 1
`define GPC_RST_OSC 2'h0
`define GPC_RST_SAMPLE 16'h0000
`define GPC_PIN_ONE 16'h0001
`define GPC_PIN_NONE 16'h0000
`define GPC_ZERO_HALF 16'h0000
`define GPC_ZERO_OSC 30'h00000000
`define GPC_ZERO_WORD 32'h00000000
`endif

//--- tb/gpc_port_asserts.sv
// Checker on the pad and bus ports of the configuration block, watching pin 0.
module gpc_chk(input wire pclk, presetn, psel, penable, pready, pslverr,
	input wire [11:0] paddr,
	input wire [31:0] pin_function_field,
	input wire [15:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down, pad_in_enable,
	input wire [15:0] peripheral_function_out, peripheral_function_in, drive_type_bit);
	timeunit 1ns;
	timeprecision 1ps;
	wire [1:0] m = pin_function_field[1:0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	alt_drive_a: assert property (m == 2'h2 && !drive_type_bit[0] |-> pad_oe[0] &&
		pad_out[0] == peripheral_function_out[0]) else $error("alternate drive wrong");
	alt_rx_a: assert property (m == 2'h2 |-> pad_in_enable[0]) else $error("receiver off");
	alt_sample_a: assert property (m == 2'h2 && $past(m) == 2'h2 |->
		peripheral_function_in[0] == $past(pad_in[0])) else $error("sample wrong");
	ana_drive_a: assert property (m == 2'h3 |-> !pad_oe[0]) else $error("analog drives");
	ana_input_a: assert property (m == 2'h3 && $past(m) == 2'h3 |->
		!peripheral_function_in[0] && !pad_in_enable[0]) else $error("analog input live");
	ana_pull_a: assert property (m == 2'h3 |-> !pad_pull_up[0] && !pad_pull_down[0])
		else $error("analog pull on");
	bus_ready_a: assert property (psel && penable |-> pready) else $error("no ready");
	bad_addr_a: assert property (psel && penable && paddr > 12'h020 |-> pslverr)
		else $error("no error");
	cover property (m == 2'h2 && pad_oe[0]);
	cover property (m == 2'h3);
	cover property (pslverr);
endmodule
bind gpc_port gpc_chk u_gpc_chk(.*);

//--- tb/gpc_pad.sv
// Pin model: a driven pin follows its driver, else an outside source, else its pull.
module gpc_pad(input wire [15:0] pad_out, pad_oe, pad_pull_up, pad_pull_down, ext_en, ext_val,
	output logic [15:0] pad_in);
	timeunit 1ns;
	timeprecision 1ps;
	// A floating pin shows the inverse of the driver, so a stale value never looks right.
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
				pad_pull_up[i] ? 1'b1 : pad_pull_down[i] ? 1'b0 : ~pad_out[i];
		end
	end
endmodule

//--- tb/gpc_port_test.sv
// Bench for the configuration block: bus accesses and pin checks.
module gpc_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rv, pad_slew;
	logic [31:0] rst [4] = '{32'hebffffff, 32'h0, 32'h0c000000, 32'h24000000};
	logic [3:0] pstrb = '0;
	logic [15:0] peripheral_function_out = '0, ext_en = '0, ext_val = '0;
	logic [15:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
	logic [15:0] pad_in_enable, peripheral_function_in, drive_type_bit;
	logic [31:0] pin_function_field;
	wire pready, pslverr;
	int fails = 0, cmp_count = 0;
	always #4 pclk = ~pclk;
	gpc_port u_gpc_port(.*);
	gpc_pad u_gpc_pad(.*);
	task automatic chk(input string n, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rst[i]) begin
			xfer(1'b0, 12'(i * 4), '0, '0);
			chk("reset", rv, rst[i]);
		end
		chk("pulls", {pad_pull_up, pad_pull_down}, 32'h20004000);
		chk("mode pins", pin_function_field, 32'hebffffff);
		xfer(1'b0, 12'h010, '0, '0);
		chk("samples", rv, 32'h0);
		$display("reset test done");
		xfer(1'b1, 12'h000, 32'h11223372, 4'h1);
		xfer(1'b0, 12'h000, '0, '0);
		chk("byte write", rv, 32'hebffff72);
		xfer(1'b1, 12'h004, 32'hffffffff, 4'hf);
		xfer(1'b0, 12'h004, '0, '0);
		chk("type", rv, 32'h0000ffff);
		chk("type pins", {16'h0, drive_type_bit}, 32'h0000ffff);
		xfer(1'b1, 12'h004, '0, 4'hf);
		xfer(1'b1, 12'h008, 32'h000000e4, 4'h1);
		chk("slew", {24'h0, pad_slew[7:0]}, 32'he4);
		xfer(1'b0, 12'h030, '0, '0);
		chk("unmapped", {rv[31:1], er}, 32'h1);
		$display("register test done");
		peripheral_function_out <= 16'h6001;
		ext_en <= 16'h0002;
		ext_val <= 16'h0002;
		repeat (2) @(posedge pclk);
		xfer(1'b0, 12'h010, '0, '0);
		chk("samples", rv, 32'h00006003);
		chk("inputs", {16'h0, peripheral_function_in}, 32'h00006003);
		chk("receivers", {16'h0, pad_in_enable}, 32'h0000600b);
		chk("drivers", {pad_oe, pad_out}, 32'h60096001);
		$display("mode test done");
		xfer(1'b1, 12'h014, 32'h00000008, 4'h3);
		xfer(1'b0, 12'h014, '0, '0);
		chk("output data", rv, 32'h00000008);
		chk("push-pull", {30'h0, pad_oe[3], pad_out[3]}, 32'h3);
		xfer(1'b1, 12'h004, 32'h00000008, 4'h3);
		chk("open drain", {30'h0, pad_oe[3], pad_out[3]}, 32'h0);
		$display("drive test done");
		xfer(1'b1, 12'h000, 32'h00000073, 4'h1);
		xfer(1'b1, 12'h020, 32'h00000003, 4'h1);
		xfer(1'b0, 12'h020, '0, '0);
		chk("oscillator", rv, 32'h3);
		chk("clock pins", {30'h0, pad_in_enable[1:0]}, 32'h2);
		xfer(1'b1, 12'h020, '0, 4'h1);
		xfer(1'b1, 12'h000, 32'h00000070, 4'h1);
		chk("free pins", {30'h0, pad_in_enable[1:0]}, 32'h3);
		$display("oscillator test done");
		stop_test();
	end
	// The tests need under a hundred cycles; this leaves ample margin.
	initial begin
		#50000;
		fails++;
		stop_test();
	end
endmodule
